// ### updown_reload_timer8.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "timer_consts.svh"
// Behaviour
// - clock select: six system divisions, watch clock over four, or event pin
// - mode bit 7 chooses interval (0) or auto-reload (1)
// - direction bits 00 count up, 01 count down; lower ignored when upper set
// - hardware direction: pin high counts down, pin low counts up
// - mode bits 4 and 3 read as one and ignore writes
// - mode register resets to 0x18
// - counter readable any time without disturbing it; writes go to reload
// - step past 0xFF up or 0x00 down sets the wrap request flag
// - interrupt only when wrap flag set and its enable is one
// - interval mode wraps to 0x00 or 0xFF and keeps direction
// - any reload write loads the counter at once
// - auto-reload mode loads reload value on each wrap
// - counter and reload share one address: read counter, write reload
// - counter and reload register reset to zero
// - counting starts right after reset in interval mode
// - external clock steps once per selected event pin edge
// - in subclock modes only watch or external clock may count
module updown_reload_timer8 (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [31:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output var  logic [31:0] O_PRDATA,
  output var  logic        O_PREADY,
  output var  logic        O_PSLVERR,
  input  wire logic        I_EVENT_INPUT_PIN,
  input  wire logic        I_COUNT_DIRECTION_PIN,
  input  wire logic        I_WATCH_CLK,
  input  wire logic        I_SUBCLOCK_MODE,
  output var  logic        O_WRAP_IRQ,
  output var  logic [7:0]  O_TIMER_COUNT
);

  logic                    setup;
  logic                    access;
  logic                    hit_mode;
  logic                    hit_count;
  logic                    hit_ctrl;
  logic                    hit_stat;
  logic                    mapped;
  logic                    wr_mode;
  logic                    wr_reload;
  logic                    wr_ctrl;
  logic                    wr_stat;
  timer_pkg::mode_type     mode_q;
  logic [7:0]              cnt_q;
  logic [7:0]              reload_q;
  logic                    irq_en_q;
  logic                    edge_sel_q;
  logic                    flag_q;
  logic [31:0]             prdata_q;
  logic [`DIV_W-1:0]       div_q;
  logic [1:0]              wdiv_q;
  timer_pkg::pin_sync_type pins;
  timer_pkg::pin_sync_type lvl;
  timer_pkg::pin_sync_type rise;
  timer_pkg::pin_sync_type fall;
  logic                    watch_tick;
  logic                    ext_tick;
  logic                    src_tick;
  logic                    halted;
  logic                    tick;
  logic                    down;
  logic                    at_limit;
  logic                    wrap_evt;
  logic [31:0]             rd_mux;

  // match a word address against a register index
  function automatic logic addr_is(input logic [31:0] a, input logic [15:0] idx);
    addr_is = (a == {14'h0, idx, 2'b00});
  endfunction

  // mode register image with the fixed ones in place
  function automatic logic [7:0] mode_pack(input timer_pkg::mode_type m);
    mode_pack = {m.reload, m.dir_src, m.sw_dir, `MODE_FIXED_ONES, m.clk_sel};
  endfunction

  // mode fields out of a byte, fixed bits dropped
  function automatic timer_pkg::mode_type mode_unpack(input logic [7:0] v);
    mode_unpack.reload  = v[`MODE_RELOAD_BIT];
    mode_unpack.dir_src = v[`MODE_DSRC_BIT];
    mode_unpack.sw_dir  = v[`MODE_SDIR_BIT];
    mode_unpack.clk_sel = timer_pkg::clksel_type'(v[`MODE_CS_MSB:`MODE_CS_LSB]);
  endfunction

  // prescaler tap for the selected internal division
  function automatic logic presc_hit(input logic [`DIV_W-1:0] c,
                                     input timer_pkg::clksel_type s);
    unique case (s)
      timer_pkg::CS_DIV8192: presc_hit = &c[`TAP_8192-1:0];
      timer_pkg::CS_DIV2048: presc_hit = &c[`TAP_2048-1:0];
      timer_pkg::CS_DIV512:  presc_hit = &c[`TAP_512-1:0];
      timer_pkg::CS_DIV64:   presc_hit = &c[`TAP_64-1:0];
      timer_pkg::CS_DIV16:   presc_hit = &c[`TAP_16-1:0];
      timer_pkg::CS_DIV4:    presc_hit = &c[`TAP_4-1:0];
      timer_pkg::CS_WATCH4,
      timer_pkg::CS_EXT:     presc_hit = 1'b0;
    endcase
  endfunction

  // apb decode; one-cycle access, no wait states
  assign setup     = I_PSEL & ~I_PENABLE;
  assign access    = I_PSEL & I_PENABLE;
  assign hit_mode  = addr_is(I_PADDR, `TMR_MODE_IDX);
  assign hit_count = addr_is(I_PADDR, `TMR_COUNT_IDX);
  assign hit_ctrl  = addr_is(I_PADDR, `TMR_CTRL_IDX);
  assign hit_stat  = addr_is(I_PADDR, `TMR_STAT_IDX);
  assign mapped    = hit_mode | hit_count | hit_ctrl | hit_stat;
  assign O_PREADY  = access;
  assign O_PSLVERR = access & ~mapped;
  assign wr_mode   = access & I_PWRITE & hit_mode;
  assign wr_reload = access & I_PWRITE & hit_count;
  assign wr_ctrl   = access & I_PWRITE & hit_ctrl;
  assign wr_stat   = access & I_PWRITE & hit_stat;

  // read image; the count address returns the live counter, never the reload value
  always_comb begin
    rd_mux = 32'h0;
    if (hit_mode) begin
      rd_mux[7:0] = mode_pack(mode_q);
    end else if (hit_count) begin
      rd_mux[7:0] = cnt_q;
    end else if (hit_ctrl) begin
      rd_mux[`CTRL_IEN_BIT]  = irq_en_q;
      rd_mux[`CTRL_EDGE_BIT] = edge_sel_q;
    end else if (hit_stat) begin
      rd_mux[`STAT_FLAG_BIT] = flag_q;
    end
  end

  // read data captured in the setup cycle, held through the access
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      prdata_q <= 32'h0;
    end else if (setup & ~I_PWRITE) begin
      prdata_q <= rd_mux;
    end
  end

  assign O_PRDATA = prdata_q;

  // mode register; fixed bits are never stored
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode_q <= mode_unpack(`TMR_MODE_RST);
    end else if (wr_mode) begin
      mode_q <= mode_unpack(I_PWDATA[7:0]);
    end
  end

  // control register: wrap interrupt enable and event edge choice
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      {edge_sel_q, irq_en_q} <= `TMR_CTRL_RST;
    end else if (wr_ctrl) begin
      irq_en_q   <= I_PWDATA[`CTRL_IEN_BIT];
      edge_sel_q <= I_PWDATA[`CTRL_EDGE_BIT];
    end
  end

  // reload register, write only
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      reload_q <= `TMR_RELOAD_RST;
    end else if (wr_reload) begin
      reload_q <= I_PWDATA[7:0];
    end
  end

  // pins into the clock domain
  assign pins = '{watch: I_WATCH_CLK, dir: I_COUNT_DIRECTION_PIN,
                  event_in: I_EVENT_INPUT_PIN};

  pin_sync u_pin_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_RST),
    .i_pins  (pins),
    .o_level (lvl),
    .o_rise  (rise),
    .o_fall  (fall)
  );

  // free-running system prescaler
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 13'h1;
    end
  end

  // watch clock divided by four on its synchronised rising edges
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      wdiv_q <= 2'h0;
    end else if (rise.watch) begin
      wdiv_q <= wdiv_q + 2'h1;
    end
  end

  assign watch_tick = rise.watch & (wdiv_q == `WATCH_DIV_LAST);

  // event edge: one selects rising, zero selects falling
  assign ext_tick = edge_sel_q ? rise.event_in : fall.event_in;

  // clock source multiplexer
  always_comb begin
    unique case (mode_q.clk_sel)
      timer_pkg::CS_WATCH4: src_tick = watch_tick;
      timer_pkg::CS_EXT:    src_tick = ext_tick;
      default:              src_tick = presc_hit(div_q, mode_q.clk_sel);
    endcase
  end

  // subclock modes stop every source except watch and external
  assign halted = I_SUBCLOCK_MODE & (mode_q.clk_sel != timer_pkg::CS_WATCH4) &
                  (mode_q.clk_sel != timer_pkg::CS_EXT);
  assign tick   = src_tick & ~halted;

  // direction: pin when hardware control selected, else software bit
  assign down     = mode_q.dir_src ? lvl.dir : mode_q.sw_dir;
  assign at_limit = down ? (cnt_q == `CNT_MIN) : (cnt_q == `CNT_MAX);
  assign wrap_evt = tick & at_limit & ~wr_reload;

  // counter: a reload write beats a step in the same cycle
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt_q <= `TMR_COUNT_RST;
    end else if (wr_reload) begin
      cnt_q <= I_PWDATA[7:0];
    end else if (tick) begin
      if (at_limit) begin
        if (mode_q.reload) begin
          cnt_q <= reload_q;
        end else begin
          cnt_q <= down ? `CNT_MAX : `CNT_MIN;
        end
      end else if (down) begin
        cnt_q <= cnt_q - 8'h01;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign O_TIMER_COUNT = cnt_q;

  // sticky wrap flag, write one to clear, a new wrap beats the clear
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      flag_q <= 1'b0;
    end else if (wrap_evt) begin
      flag_q <= 1'b1;
    end else if (wr_stat & I_PWDATA[`STAT_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // interrupt request gated by its enable
  assign O_WRAP_IRQ = flag_q & irq_en_q;

  // checks kept next to the logic they guard
  a_reload_load_wins: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    wr_reload |=> (cnt_q == $past(I_PWDATA[7:0])))
    else $error("reload write did not load the counter");

  a_interval_up_wrap: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (tick && !down && cnt_q == 8'hFF && !mode_q.reload && !wr_reload)
    |=> (cnt_q == 8'h00))
    else $error("interval overflow did not wrap to zero");

  a_interval_down_wrap: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (tick && down && cnt_q == 8'h00 && !mode_q.reload && !wr_reload)
    |=> (cnt_q == 8'hFF))
    else $error("interval underflow did not wrap to all ones");

  a_auto_reload_load: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (tick && at_limit && mode_q.reload && !wr_reload)
    |=> (cnt_q == $past(reload_q)))
    else $error("auto-reload wrap did not load the reload value");

  a_wrap_sets_flag: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (tick && !wr_reload && ((!down && cnt_q == 8'hFF) || (down && cnt_q == 8'h00)))
    |=> flag_q)
    else $error("wrap did not set the request flag");

  a_irq_needs_both: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    O_WRAP_IRQ |-> (flag_q && irq_en_q && $past(irq_en_q) | wr_ctrl | $past(wr_ctrl)))
    else $error("interrupt raised without flag and enable");

  a_pin_down_step: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (tick && mode_q.dir_src && lvl.dir && cnt_q != 8'h00 && !wr_reload)
    |=> (cnt_q == $past(cnt_q) - 8'h01))
    else $error("high direction pin did not count down");

  a_subclock_halt: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (I_SUBCLOCK_MODE && mode_q.clk_sel[2:1] != 2'b11 && !wr_reload) |=> $stable(cnt_q))
    else $error("counter moved in subclock mode on a halted source");

  a_div4_step: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (mode_q.clk_sel == timer_pkg::CS_DIV4 && !I_SUBCLOCK_MODE && div_q[1:0] == 2'b11 &&
     !down && cnt_q != 8'hFF && !wr_reload) |=> (cnt_q == $past(cnt_q) + 8'h01))
    else $error("system clock over four did not step the counter");

  a_count_readback: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (setup && !I_PWRITE && hit_count) |=> (O_PRDATA == {24'h0, $past(cnt_q)}))
    else $error("count read did not return the counter");

  a_mode_fixed_ones: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (setup && !I_PWRITE && hit_mode) |=> (O_PRDATA[4:3] == 2'b11))
    else $error("mode bits four and three did not read one");

  a_soft_up_step: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (tick && !mode_q.dir_src && !mode_q.sw_dir && cnt_q != 8'hFF && !wr_reload)
    |=> (cnt_q == $past(cnt_q) + 8'h01))
    else $error("software up direction did not count up");

  a_soft_down_step: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (tick && !mode_q.dir_src && mode_q.sw_dir && cnt_q != 8'h00 && !wr_reload)
    |=> (cnt_q == $past(cnt_q) - 8'h01))
    else $error("software down direction did not count down");

  a_ext_fall_step: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
    (mode_q.clk_sel == timer_pkg::CS_EXT && !edge_sel_q && fall.event_in && !down &&
     cnt_q != 8'hFF && !wr_reload) |=> (cnt_q == $past(cnt_q) + 8'h01))
    else $error("falling event edge did not step the counter");

endmodule
`default_nettype wire

// ### timer_consts.svh
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// register indices, byte address is four times the index
`define TMR_MODE_IDX     16'hFFB4
`define TMR_COUNT_IDX    16'hFFB5
`define TMR_CTRL_IDX     16'hFFC0
`define TMR_STAT_IDX     16'hFFC1

// reset values
`define TMR_MODE_RST     8'h18
`define TMR_COUNT_RST    8'h00
`define TMR_RELOAD_RST   8'h00
`define TMR_CTRL_RST     2'h0

// mode register field positions
`define MODE_RELOAD_BIT  7
`define MODE_DSRC_BIT    6
`define MODE_SDIR_BIT    5
`define MODE_CS_MSB      2
`define MODE_CS_LSB      0
`define MODE_FIXED_ONES  2'h3

// control and status field positions
`define CTRL_IEN_BIT     0
`define CTRL_EDGE_BIT    1
`define STAT_FLAG_BIT    0

// counter limits
`define CNT_MAX          8'hFF
`define CNT_MIN          8'h00

// prescaler taps, as log2 of the division
`define DIV_W            13
`define TAP_8192         13
`define TAP_2048         11
`define TAP_512          9
`define TAP_64           6
`define TAP_16           4
`define TAP_4            2
`define WATCH_DIV_LAST   2'h3

`endif

// ### timer_pkg.sv
package timer_pkg;

  typedef enum logic [2:0] {
    CS_DIV8192 = 3'b000,
    CS_DIV2048 = 3'b001,
    CS_DIV512  = 3'b010,
    CS_DIV64   = 3'b011,
    CS_DIV16   = 3'b100,
    CS_DIV4    = 3'b101,
    CS_WATCH4  = 3'b110,
    CS_EXT     = 3'b111
  } clksel_type;

  typedef struct packed {
    logic       reload;
    logic       dir_src;
    logic       sw_dir;
    clksel_type clk_sel;
  } mode_type;

  typedef struct packed {
    logic watch;
    logic dir;
    logic event_in;
  } pin_sync_type;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire timer_pkg::pin_sync_type i_pins,
  output var  timer_pkg::pin_sync_type o_level,
  output var  timer_pkg::pin_sync_type o_rise,
  output var  timer_pkg::pin_sync_type o_fall
);

  timer_pkg::pin_sync_type s1_q;
  timer_pkg::pin_sync_type s2_q;
  timer_pkg::pin_sync_type s3_q;

  // two-stage synchroniser plus one history stage for edges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // single-cycle edge pulses from synchronised levels
  assign o_level = s2_q;
  assign o_rise  = s2_q & ~s3_q;
  assign o_fall  = ~s2_q & s3_q;

endmodule
`default_nettype wire

// ### far_side_pins.sv
`timescale 1ns/1ns
`default_nettype none
module far_side_pins (
  input  wire logic i_clk,
  output var  logic o_event,
  output var  logic o_dir,
  output var  logic o_watch
);
  // watch crystal runs free, unrelated in phase to the system clock
  initial begin
    o_event = 1'b0;
    o_dir = 1'b0;
    o_watch = 1'b0;
    forever #130 o_watch = ~o_watch;
  end
  // event level held long enough to pass the synchroniser
  task automatic event_edge(input logic lvl);
    @(posedge i_clk);
    o_event <= lvl;
    repeat (6) @(posedge i_clk);
  endtask
  // direction level, held steady while the counter uses it
  task automatic set_dir(input logic down);
    @(posedge i_clk);
    o_dir <= down;
    repeat (4) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ### tb_updown_reload_timer8.sv
`timescale 1ns/1ns
`default_nettype none
module tb_updown_reload_timer8;
  localparam logic [31:0] MODE = 32'h0003FED0;
  localparam logic [31:0] CNTA = 32'h0003FED4;
  localparam logic [31:0] CTRL = 32'h0003FF00;
  localparam logic [31:0] STAT = 32'h0003FF04;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [31:0] padr;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        ev;
  logic        dir;
  logic        wclk;
  logic        sub;
  logic        irq;
  logic [7:0]  cnt;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          samples_checked;

  updown_reload_timer8 u_dut (
    .I_REF_CLK            (clk),
    .I_RST                (rst),
    .I_PSEL               (psel),
    .I_PENABLE            (pen),
    .I_PWRITE             (pwr),
    .I_PADDR              (padr),
    .I_PWDATA             (pwd),
    .O_PRDATA             (prd),
    .O_PREADY             (prdy),
    .O_PSLVERR            (perr),
    .I_EVENT_INPUT_PIN    (ev),
    .I_COUNT_DIRECTION_PIN(dir),
    .I_WATCH_CLK          (wclk),
    .I_SUBCLOCK_MODE      (sub),
    .O_WRAP_IRQ           (irq),
    .O_TIMER_COUNT        (cnt)
  );
  far_side_pins u_pins (.i_clk(clk), .o_event(ev), .o_dir(dir), .o_watch(wclk));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    if (prdy !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // bounded wait for the counter to move; n is the cycles taken
  task automatic wait_change(input int lim, output int n);
    logic [7:0] old;
    @(negedge clk);
    old = cnt;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cnt === old && n < lim);
    if (cnt === old) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // bounded wait for the counter to leave prev, then compare with the next value
  task automatic step(input logic [7:0] prev, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cnt === prev && n < 20);
    check({24'h0, cnt}, {24'h0, e});
  endtask

  task automatic reset_values();
    int n;
    rdc(MODE, 32'h18);
    rdc(CNTA, 32'h0);
    rdc(CTRL, 32'h0);
    wait_change(9000, n);
    check({24'h0, cnt}, 32'h1);
  endtask
  task automatic reserved_bits();
    wr(MODE, 32'h0);
    rdc(MODE, 32'h18);
    wr(MODE, 32'hE7);
    rdc(MODE, 32'hFF);
  endtask
  task automatic clock_divisions();
    int div [6] = '{8192, 2048, 512, 64, 16, 4};
    int n;
    for (int cs = 0; cs < 6; cs++) begin
      wr(MODE, {29'h0, cs[2:0]});
      wait_change(9000, n);
      wait_change(9000, n);
      // the negedge on which the old value was taken is not counted
      check(n + 1, div[cs]);
    end
  endtask
  task automatic interval_wrap();
    wr(MODE, 32'h1D);
    wr(STAT, 32'h1);
    wr(CNTA, 32'hFD);
    @(negedge clk);
    check({24'h0, cnt}, 32'hFD);
    step(8'hFD, 8'hFE);
    step(8'hFE, 8'hFF);
    step(8'hFF, 8'h00);
    rdc(STAT, 32'h1);
    step(8'h00, 8'h01);
    // down by software, then by the direction pin (port function assumed set)
    wr(MODE, 32'h3D);
    wr(STAT, 32'h1);
    wr(CNTA, 32'h01);
    step(8'h01, 8'h00);
    step(8'h00, 8'hFF);
    rdc(STAT, 32'h1);
    u_pins.set_dir(1'b1);
    wr(MODE, 32'h5D);
    wr(CNTA, 32'h80);
    step(8'h80, 8'h7F);
    u_pins.set_dir(1'b0);
    wr(MODE, 32'h7D);
    wr(CNTA, 32'h40);
    step(8'h40, 8'h41);
  endtask
  task automatic reload_irq();
    wr(MODE, 32'h9D);
    wr(CTRL, 32'h0);
    wr(STAT, 32'h1);
    wr(CNTA, 32'hFE);
    step(8'hFE, 8'hFF);
    step(8'hFF, 8'hFE);
    rdc(STAT, 32'h1);
    check({31'h0, irq}, 32'h0);
    // a zero reload keeps the next wrap far away while the enable is checked
    wr(CNTA, 32'h00);
    wr(CTRL, 32'h1);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    wr(STAT, 32'h1);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    // counting down in reload mode reloads on underflow
    wr(MODE, 32'hBD);
    wr(CNTA, 32'h01);
    step(8'h01, 8'h00);
    step(8'h00, 8'h01);
  endtask
  task automatic event_count();
    // rising event edge selected and wrap irq kept off first
    wr(CTRL, 32'h2);
    wr(MODE, 32'h1F);
    wr(CNTA, 32'h10);
    rdc(CNTA, 32'h10);
    u_pins.event_edge(1'b1);
    check({24'h0, cnt}, 32'h11);
    u_pins.event_edge(1'b0);
    check({24'h0, cnt}, 32'h11);
    wr(CTRL, 32'h0);
    u_pins.event_edge(1'b1);
    check({24'h0, cnt}, 32'h11);
    u_pins.event_edge(1'b0);
    check({24'h0, cnt}, 32'h12);
  endtask
  task automatic subclock();
    logic [7:0] old;
    int n;
    wr(MODE, 32'h1D);
    sub <= 1'b1;
    @(negedge clk);
    old = cnt;
    repeat (40) @(negedge clk);
    check({24'h0, cnt}, {24'h0, old});
    wr(MODE, 32'h1E);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cnt === old && n < 200);
    check({24'h0, cnt}, {24'h0, old + 8'h01});
    @(posedge clk);
    sub <= 1'b0;
  endtask
  task automatic unmapped();
    wr(32'h0003FED8, 32'hFF);
    check({31'h0, err}, 32'h1);
    rdc(32'h0003FED8, 32'h0);
    check({31'h0, err}, 32'h1);
    rdc(MODE, 32'h1E);
  endtask
  // reset again in mid-run: registers and flag return to their reset values
  task automatic mid_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(MODE, 32'h18);
    rdc(CNTA, 32'h0);
    rdc(STAT, 32'h0);
    // reload mode counting down from zero shows the cleared reload value
    wr(MODE, 32'hBD);
    repeat (8) @(posedge clk);
    rdc(STAT, 32'h1);
    @(negedge clk);
    check({24'h0, cnt}, 32'h0);
  endtask

  initial begin
    miscompares = 0;
    samples_checked = 0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    padr = 32'h0;
    sub = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    reserved_bits();
    clock_divisions();
    interval_wrap();
    reload_irq();
    event_count();
    subclock();
    unmapped();
    mid_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
